// *** core/dmd_regs.svh ***
/*
 * constants for the data-move decoder: opcode fields, address limits, phases.
 * assumes a 16-bit program word and a 12-bit data address space.
 */
`ifndef DMD_REGS_SVH
`define DMD_REGS_SVH

// ------------------------------------------------------------
// opcode prefixes
// ------------------------------------------------------------
`define DMD_OPC_BANK_LIT   8'h01
`define DMD_OPC_WORK_LIT   8'h0e
`define DMD_OPC_STORE_WORK 7'h37
`define DMD_OPC_MOVE_SRC   4'hc
`define DMD_OPC_MOVE_DST   4'hf

// ------------------------------------------------------------
// addressing
// ------------------------------------------------------------
`define DMD_INDEX_LIMIT    8'h5f
`define DMD_ACCESS_LO_PAGE 4'h0
`define DMD_ACCESS_HI_PAGE 4'hf
`define DMD_BANK_MASK      8'h0f

// ------------------------------------------------------------
// phases and reset values
// ------------------------------------------------------------
`define DMD_PH_Q1          2'h0
`define DMD_PH_Q2          2'h1
`define DMD_PH_Q3          2'h2
`define DMD_PH_Q4          2'h3
`define DMD_BANK_RESET     8'h00
`define DMD_WORK_RESET     8'h00

`endif

// *** core/dmd_pkg.sv ***
/*
 * types shared by the data-move decoder.
 * assumes nothing beyond the constants header.
 */
package dmd_pkg;

    typedef enum logic [2:0] {
        OP_NONE  = 3'b000,
        OP_BANK  = 3'b001,
        OP_WORK  = 3'b010,
        OP_STORE = 3'b011,
        OP_MOVE1 = 3'b100,
        OP_MOVE2 = 3'b101
    } dmd_op_t;

    typedef struct packed {
        logic [11:0] addr;
        logic [7:0]  wdata;
        logic        re;
        logic        we;
    } dmd_mem_req_t;

endpackage

// *** core/dmd_core.sv ***
/*
 * decode and execute of the literal-to-bank, literal-to-work, work-to-file
 * and two-word file-to-file moves.
 * assumes one clk per quarter phase, a word offered during q1 and a data
 * memory that returns read data one clk after its read strobe.
 */
// Contract
// - load_bank_literal writes the literal to the bank select register with bits 7:4 forced to zero.
// - load_bank_literal is one word and one cycle: literal read in q2, processed in q3, written in q4.
// - load_work_literal puts the literal in the working register in one cycle and touches no flag.
// - store_work_to_file copies the working register to the addressed file in one cycle, flags untouched.
// - store_work_to_file with access bit 0 uses the access bank, with 1 the bank select register's bank.
// - the 8-bit file address reaches every location of the selected 256-byte bank.
// - with the extended set on, access bit 0 and address at most 5fh, indexed literal offset is used.
module dmd_core
    import dmd_pkg::*;
(
    input  wire logic          clk,
    input  wire logic          reset_n,
    input  wire logic          instr_valid,
    input  wire logic [15:0]   instr_word,
    input  wire logic          ext_set_en,
    input  wire logic [11:0]   index_base,
    input  wire logic [7:0]    mem_rdata,
    output dmd_mem_req_t       mem_req_q,
    output logic [7:0]         bank_select_q,
    output logic [7:0]         work_q,
    output logic [1:0]         phase_q,
    output logic               word_taken_q,
    output logic               unknown_op_q,
    output logic               flags_we_q
);
`include "dmd_regs.svh"

    // ------------------------------------------------------------
    // decode state
    // ------------------------------------------------------------
    dmd_op_t      op_q;
    logic [15:0]  ir_q;
    logic [7:0]   lit_q;
    logic [7:0]   hold_q;
    logic         take;
    logic [11:0]  store_addr;

    // a second move word is always taken, even without valid, to keep pairing
    assign take = (phase_q == `DMD_PH_Q1) && (instr_valid || op_q == OP_MOVE1);

    // ------------------------------------------------------------
    // opcode matches on the offered word
    // ------------------------------------------------------------
    logic         hit_bank;
    logic         hit_work;
    logic         hit_store;
    logic         hit_move;
    logic         hit_dest;

    assign hit_bank  = instr_word[15:8] == `DMD_OPC_BANK_LIT;
    assign hit_work  = instr_word[15:8] == `DMD_OPC_WORK_LIT;
    assign hit_store = instr_word[15:9] == `DMD_OPC_STORE_WORK;
    assign hit_move  = instr_word[15:12] == `DMD_OPC_MOVE_SRC;
    assign hit_dest  = instr_word[15:12] == `DMD_OPC_MOVE_DST;

    // ------------------------------------------------------------
    // file address of store_work_to_file
    // ------------------------------------------------------------
    function automatic logic [11:0] file_addr(input logic a, input logic [7:0] f,
                                              input logic [7:0] bank, input logic ext,
                                              input logic [11:0] base);
        logic [11:0] r;
        r = 12'h000;
        if (a) begin
            r = {bank[3:0], f};
        end else if (ext && f <= `DMD_INDEX_LIMIT) begin
            r = 12'(base + {4'h0, f});
        end else if (f <= `DMD_INDEX_LIMIT) begin
            r = {`DMD_ACCESS_LO_PAGE, f};
        end else begin
            r = {`DMD_ACCESS_HI_PAGE, f};
        end
        return r;
    endfunction

    assign store_addr = file_addr(ir_q[8], ir_q[7:0], bank_select_q, ext_set_en, index_base);

    // ------------------------------------------------------------
    // quarter-phase divider
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            phase_q <= `DMD_PH_Q1;
        end else begin
            phase_q <= 2'(phase_q + 2'h1);
        end
    end

    // ------------------------------------------------------------
    // decode in q1
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            op_q <= OP_NONE;
            ir_q <= 16'h0000;
        end else if (take) begin
            ir_q <= instr_word;
            if (op_q == OP_MOVE1) begin
                op_q <= OP_MOVE2;
            end else if (hit_bank) begin
                op_q <= OP_BANK;
            end else if (hit_work) begin
                op_q <= OP_WORK;
            end else if (hit_store) begin
                op_q <= OP_STORE;
            end else if (hit_move) begin
                op_q <= OP_MOVE1;
            end else begin
                op_q <= OP_NONE;
            end
        end else if (phase_q == `DMD_PH_Q1) begin
            op_q <= OP_NONE;
        end
    end

    // ------------------------------------------------------------
    // word accepted strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            word_taken_q <= 1'b0;
        end else begin
            word_taken_q <= take;
        end
    end

    // ------------------------------------------------------------
    // foreign opcodes, and a second move word of the wrong kind
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            unknown_op_q <= 1'b0;
        end else if (take && op_q == OP_MOVE1) begin
            // a wrong second word still ends the move so the core never hangs
            unknown_op_q <= !hit_dest;
        end else if (take) begin
            unknown_op_q <= !(hit_bank || hit_work || hit_store || hit_move);
        end else begin
            unknown_op_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // literal read in q2, source data caught at the end of q3
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            lit_q      <= 8'h00;
            hold_q     <= 8'h00;
        end else begin
            if (phase_q == `DMD_PH_Q2) begin
                lit_q <= ir_q[7:0];
            end
            if (phase_q == `DMD_PH_Q3 && op_q == OP_MOVE1) begin
                hold_q <= mem_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // bank select and working register, written for q4
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bank_select_q <= `DMD_BANK_RESET;
            work_q        <= `DMD_WORK_RESET;
        end else if (phase_q == `DMD_PH_Q3) begin
            if (op_q == OP_BANK) begin
                bank_select_q <= lit_q & `DMD_BANK_MASK;
            end
            if (op_q == OP_WORK) begin
                work_q <= lit_q;
            end
        end
    end

    // ------------------------------------------------------------
    // data memory strobes
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            mem_req_q <= '0;
        end else begin
            mem_req_q.re <= 1'b0;
            mem_req_q.we <= 1'b0;
            if (phase_q == `DMD_PH_Q1 && take && op_q != OP_MOVE1 && hit_move) begin
                // only the first move word reads; the second does no dummy read
                mem_req_q.re   <= 1'b1;
                mem_req_q.addr <= instr_word[11:0];
            end else if (phase_q == `DMD_PH_Q3 && op_q == OP_STORE) begin
                mem_req_q.we    <= 1'b1;
                mem_req_q.addr  <= store_addr;
                mem_req_q.wdata <= work_q;
            end else if (phase_q == `DMD_PH_Q3 && op_q == OP_MOVE2) begin
                mem_req_q.we    <= 1'b1;
                mem_req_q.addr  <= ir_q[11:0];
                mem_req_q.wdata <= hold_q;
            end
        end
    end

    // ------------------------------------------------------------
    // status flags: none of these moves writes them
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            flags_we_q <= 1'b0;
        end else begin
            flags_we_q <= 1'b0;
        end
    end

endmodule

// *** tb/dmd_monitor.sv ***
/* checker for the data-move decoder ports.
   assumes it is bound to dmd_core and one word is taken per four clk. */
module dmd_monitor
    import dmd_pkg::*;
(
    input wire logic         clk,
    input wire logic         reset_n,
    input wire logic         instr_valid,
    input wire logic [15:0]  instr_word,
    input wire logic         ext_set_en,
    input wire logic [11:0]  index_base,
    input wire logic [7:0]   mem_rdata,
    input wire dmd_mem_req_t mem_req_q,
    input wire logic [7:0]   bank_select_q,
    input wire logic [7:0]   work_q,
    input wire logic [1:0]   phase_q,
    input wire logic         word_taken_q,
    input wire logic         unknown_op_q,
    input wire logic         flags_we_q
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    wire       take = phase_q == 2'h0 && instr_valid;
    wire [7:0] f    = instr_word[7:0];
    wire       st   = take && instr_word[15:9] == 7'h37;
    wire       idx  = ext_set_en && f <= 8'h5f;
    sequence s_read;
        mem_req_q.re && mem_req_q.addr == $past(instr_word[11:0]);
    endsequence
    sequence s_write;
        (!mem_req_q.re && !mem_req_q.we) [*5] ##1 (mem_req_q.we && mem_req_q.addr == $past(instr_word[11:0], 3)
            && mem_req_q.wdata == $past(mem_rdata, 5));
    endsequence
    AST_PHASE:
    assert property (1'b1 |=> phase_q == 2'($past(phase_q) + 2'h1)) else $error("phase did not advance");
    AST_TAKEN:
    assert property (take |=> word_taken_q) else $error("word offered in q1 not taken");
    AST_TAKEN_Q1:
    assert property (word_taken_q |-> $past(phase_q) == 2'h0) else $error("word taken outside q1");
    AST_UNKNOWN:
    assert property (unknown_op_q |-> word_taken_q) else $error("unknown flag without a taken word");
    AST_BANK_HI:
    assert property (bank_select_q[7:4] == 4'h0) else $error("bank upper bits set");
    AST_BANK_Q4:
    assert property (take && instr_word[15:8] == 8'h01 |-> ##2 $stable(bank_select_q) ##1
        bank_select_q == {4'h0, $past(instr_word[3:0], 3)}) else $error("bank load wrong");
    AST_WORK:
    assert property (take && instr_word[15:8] == 8'h0e |-> ##2 $stable(work_q) ##1
        work_q == $past(f, 3)) else $error("work load wrong");
    AST_FLAGS:
    assert property (flags_we_q == 1'b0) else $error("flag write seen");
    AST_ST_DATA:
    assert property (st |-> ##2 !mem_req_q.we ##1 (mem_req_q.we && mem_req_q.wdata == $past(work_q, 3)))
        else $error("store data wrong");
    AST_ST_BANK:
    assert property (st && instr_word[8] |-> ##3 mem_req_q.addr == {$past(bank_select_q[3:0], 3), $past(f, 3)})
        else $error("banked address wrong");
    AST_ST_IDX:
    assert property (st && !instr_word[8] && idx |-> ##3
        mem_req_q.addr == 12'($past(index_base, 3) + {4'h0, $past(f, 3)})) else $error("indexed address wrong");
    AST_ST_ACC:
    assert property (st && !instr_word[8] && !idx |-> ##3
        mem_req_q.addr == {($past(f, 3) > 8'h5f) ? 4'hf : 4'h0, $past(f, 3)}) else $error("access address wrong");
    AST_MOVE:
    assert property (take && instr_word[15:12] == 4'hc |=> s_read ##1 s_write) else $error("move sequence wrong");
endmodule

bind dmd_core dmd_monitor mon_u (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
    .instr_word(instr_word), .ext_set_en(ext_set_en), .index_base(index_base), .mem_rdata(mem_rdata),
    .mem_req_q(mem_req_q), .bank_select_q(bank_select_q), .work_q(work_q), .phase_q(phase_q),
    .word_taken_q(word_taken_q), .unknown_op_q(unknown_op_q), .flags_we_q(flags_we_q));

// *** tb/dmd_mem_model.sv ***
/* behavioural data memory facing the decoder.
   assumes read data is due one clk after the read strobe. */
module dmd_mem_model
    import dmd_pkg::*;
(
    input  wire logic         clk,
    input  wire dmd_mem_req_t req,
    output logic [7:0]        rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] mem [4096];
    initial rdata = 8'h00;
    always @(posedge clk) begin
        // outside the read slot the bus toggles, so a sample an odd number of clk late sees inverted data
        rdata <= req.re ? mem[req.addr] : ~rdata;
        if (req.we) begin
            mem[req.addr] <= req.wdata;
        end
    end
endmodule

// *** tb/data_move_instruction_decode_bench.sv ***
/* self-checking bench for the data-move decoder.
   assumes dmd_core, the memory model and the bound checker. */
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin err_count++; \
    $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module data_move_instruction_decode_bench
    import dmd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk = 0, reset_n = 0, instr_valid = 0, ext_set_en = 0;
    logic [15:0]  instr_word = 16'h0000;
    logic [11:0]  index_base = 12'h000;
    logic [7:0]   mem_rdata, bank_select_q, work_q;
    dmd_mem_req_t mem_req_q;
    logic [1:0]   phase_q;
    logic         word_taken_q, unknown_op_q, flags_we_q;
    int           err_count = 0, checks = 0;
    always #12.5 clk = ~clk;
    dmd_core dut_u (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid), .instr_word(instr_word),
        .ext_set_en(ext_set_en), .index_base(index_base), .mem_rdata(mem_rdata), .mem_req_q(mem_req_q),
        .bank_select_q(bank_select_q), .work_q(work_q), .phase_q(phase_q), .word_taken_q(word_taken_q),
        .unknown_op_q(unknown_op_q), .flags_we_q(flags_we_q));
    dmd_mem_model mem_u (.clk(clk), .req(mem_req_q), .rdata(mem_rdata));
    function automatic logic [7:0] exp_bank(logic [7:0] k);
        return {4'h0, k[3:0]};
    endfunction
    function automatic logic [11:0] exp_addr(logic a, logic ext, logic [7:0] f, logic [7:0] b, logic [11:0] x);
        if (a) return {b[3:0], f};
        if (ext && f <= 8'h5f) return x + {4'h0, f};
        return {(f > 8'h5f) ? 4'hf : 4'h0, f};
    endfunction
    task automatic results();
        $display("checks=%0d mismatches=%0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic issue(input logic [15:0] w);
        int n;
        n = 0;
        while (phase_q !== 2'h0) begin
            @(negedge clk);
            n++;
            if (n > 8) begin
                err_count++;
                results();
            end
        end
        instr_valid = 1'b1;
        instr_word = w;
        @(negedge clk);
        instr_valid = 1'b0;
        `CHK(word_taken_q, 1'b1)
    endtask
    initial begin
        logic [7:0]  k, w, f;
        logic [7:0]  fc [4];
        logic [11:0] a, s;
        fc = '{8'h5f, 8'h60, 8'h00, 8'hff};
        void'($urandom(10));
        index_base = 12'($urandom);
        repeat (3) @(negedge clk);
        reset_n = 1'b1;
        for (int i = 0; i < 6; i++) begin
            k = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($urandom);
            issue({8'h01, k});
            `CHK(unknown_op_q, 1'b0)
            issue({8'h0e, ~k});
            repeat (4) @(negedge clk);
            `CHK(bank_select_q, exp_bank(k))
            `CHK(work_q, ~k)
        end
        $display("test literals done");
        for (int i = 0; i < 20; i++) begin
            k = 8'($urandom);
            w = 8'($urandom);
            f = (i < 16) ? fc[i[3:2]] : 8'($urandom);
            ext_set_en = i[1];
            a = exp_addr(i[0], i[1], f, exp_bank(k), index_base);
            mem_u.mem[a] = ~w;
            issue({8'h01, k});
            issue({8'h0e, w});
            issue({7'h37, i[0], f});
            repeat (4) @(negedge clk);
            `CHK(mem_u.mem[a], w)
        end
        $display("test store done");
        for (int i = 0; i < 4; i++) begin
            s = (i == 0) ? 12'hfff : 12'($urandom);
            w = 8'($urandom);
            mem_u.mem[s] = w;
            mem_u.mem[~s] = ~w;
            issue({4'hc, s});
            issue({4'hf, ~s});
            repeat (4) @(negedge clk);
            `CHK(mem_u.mem[~s], w)
        end
        $display("test move done");
        issue({4'hc, 12'h000});
        issue(16'h0000);
        `CHK(unknown_op_q, 1'b1)
        for (int i = 0; i < 4; i++) begin
            k = bank_select_q;
            w = work_q;
            issue((i == 0) ? 16'h0d00 : {4'h5, 12'($urandom)});
            `CHK(unknown_op_q, 1'b1)
            @(negedge clk);
            instr_valid = 1'b1;
            instr_word = {8'h01, ~k};
            @(negedge clk);
            instr_valid = 1'b0;
            `CHK(word_taken_q, 1'b0)
            repeat (4) @(negedge clk);
            `CHK(bank_select_q, k)
            `CHK(work_q, w)
        end
        $display("test refusals done");
        results();
    end
endmodule
